// ---- hdl/ldcs_map.svh ----
/*
 * Register offsets, descriptor control word fields and reset values of
 * the link descriptor control sequencer.
 * Assumes an 8-bit AXI4-Lite byte address and 32-bit data.
 */
`ifndef LDCS_MAP_SVH
`define LDCS_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LDCS_REG_CTRL      8'h00
`define LDCS_REG_ADVANCE   8'h04
`define LDCS_REG_FIRST     8'h08
`define LDCS_REG_STATUS    8'h0c
`define LDCS_REG_IRQ_STAT  8'h10
`define LDCS_REG_IRQ_MASK  8'h14

// ----------------------------------------------------------------------
// register fields and reset values
// ----------------------------------------------------------------------
`define LDCS_CTRL_RUN      0
`define LDCS_ADV_BIT       0
`define LDCS_IRQ_LINK      0
`define LDCS_IRQ_CHAIN     1
`define LDCS_RST_CTRL      1'h0
`define LDCS_RST_FIRST     16'h0000
`define LDCS_RST_IRQ       2'h0
`define LDCS_RESP_OKAY     2'h0
`define LDCS_RESP_SLVERR   2'h2

// ----------------------------------------------------------------------
// link descriptor flags word
// ----------------------------------------------------------------------
`define LDCS_CW_LOOPCNT    31:16
`define LDCS_CW_KIND       13:12
`define LDCS_CW_META       11
`define LDCS_CW_LAST       10
`define LDCS_CW_CHAINIRQ   9
`define LDCS_CW_LINKIRQ    8
`define LDCS_CW_STOPEOP    7
`define LDCS_CW_STEP       3
`define LDCS_CW_SOPGATE    2
`define LDCS_CW_AUTO       0

`endif

// ---- hdl/ldcs_pkg.sv ----
/*
 * Types of the link descriptor control sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ldcs_pkg;

    // descriptor as returned by the descriptor store
    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] byteCount;
        logic [63:0] destAddr;
        logic [63:0] metaAddr;
        logic [31:0] loopStride;
        logic [15:0] nextLink;
    } ldcs_desc_t;

    // one transfer order to the data mover
    typedef struct packed {
        logic [63:0] destAddr;
        logic [63:0] metaAddr;
        logic [31:0] byteCount;
        logic [1:0]  requestAddressKind;
        logic        metaEnable;
        logic        stopOnEop;
    } ldcs_xfer_t;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_FETCH = 6'h02,
        ST_ARM   = 6'h04,
        ST_GATE  = 6'h08,
        ST_RUN   = 6'h10,
        ST_STEP  = 6'h20
    } ldcs_state_t;

endpackage

// ---- hdl/ldcs_sequencer.sv ----
/*
 * Per-link control sequencer of a stream-to-PCIe write DMA: walks a
 * linked list of descriptors, launches, repeats and ends transfers,
 * raises link and chain interrupts; AXI4-Lite register slave.
 * Assumes a descriptor store answering descReq with descValid, and a
 * data mover taking xferStart and reporting xferDone.
 */
// How it works
// - incr mode repeats the link loop-count times before moving on.
// - the two-bit address kind goes into every write request header.
// - metadata packets are written only when the metadata bit is set.
// - a final link ends the chain; no successor is fetched.
// - chain-done event raised at chain end only if its enable bit is set.
// - link-done event raised per finished link only if its enable bit is set.
// - stop-on-eop set ends the transfer at the next end of packet.
// - stop-on-eop clear ignores end of packet; byte count ends it.
// - stepping adds the stride to the destination after each pass.
// - packet-gated launch waits for start of packet with gate high.
// - without packet gating the launch ignores the gate.
// - manual mode waits for a host toggle of the advance bit.
// - auto mode launches every link after the first without an advance toggle.
// - the first link of a chain always waits for an advance toggle.
// - after a non-final link the successor pointer is fetched.
// - the stride is the 32-bit descriptor word added when stepping.
// - each cycle with an enabled interrupt event gives a one-cycle pulse; link and chain events of one cycle share it.
`timescale 1ns/1ps
`include "ldcs_map.svh"

module ldcs_sequencer (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic                     descReq,
    output logic [15:0]              descAddr,
    input  wire logic                descValid,
    input  wire ldcs_pkg::ldcs_desc_t descData,
    input  wire logic                streamSop,
    input  wire logic                streamEop,
    input  wire logic                streamGate,
    output logic                     xferStart,
    output logic                     xferAbort,
    output ldcs_pkg::ldcs_xfer_t     xferOrder,
    input  wire logic                xferDone,
    output logic                     irq,
    output logic                     irqPulse
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic                  run, next_run, runPrev;
    logic                  advBit, next_advBit, advRef, next_advRef;
    logic [15:0]           firstLink, next_firstLink;
    logic [1:0]            irqStat, next_irqStat, irqMask, next_irqMask;
    logic                  bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0]            bresp, next_bresp, rresp, next_rresp;
    logic [31:0]           rdata, next_rdata;
    logic                  wrTake;
    ldcs_pkg::ldcs_state_t state, next_state;
    ldcs_pkg::ldcs_desc_t  desc, next_desc;
    ldcs_pkg::ldcs_xfer_t  next_xferOrder;
    logic [63:0]           curDest, next_curDest;
    logic [15:0]           passCnt, next_passCnt, linkAddr, next_linkAddr;
    logic                  firstLinkOfChain, next_firstLinkOfChain;
    logic                  next_xferStart, next_xferAbort;
    logic                  evtLink, next_evtLink, evtChain, next_evtChain;
    logic                  next_irqPulse;
    logic                  linkFinal, launchOk;

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    // write channels taken together, only while no response is pending
    assign wrTake        = s_axi_awvalid & s_axi_wvalid & ~bvalid;
    assign s_axi_awready = wrTake;
    assign s_axi_wready  = wrTake;
    assign s_axi_arready = ~rvalid;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;

    // register next values; hardware events win over write-one-to-clear
    always_comb begin
        next_run       = run;
        next_advBit    = advBit;
        next_firstLink = firstLink;
        next_irqMask   = irqMask;
        next_irqStat   = irqStat;
        next_bvalid    = bvalid & ~s_axi_bready;
        next_bresp     = bresp;
        next_rvalid    = rvalid & ~s_axi_rready;
        next_rresp     = rresp;
        next_rdata     = rdata;
        if (wrTake) begin
            next_bvalid = 1'b1;
            next_bresp  = `LDCS_RESP_OKAY;
            unique case (s_axi_awaddr)
                `LDCS_REG_CTRL: begin
                    if (s_axi_wstrb[0]) next_run = s_axi_wdata[`LDCS_CTRL_RUN];
                end
                `LDCS_REG_ADVANCE: begin
                    if (s_axi_wstrb[0]) next_advBit = s_axi_wdata[`LDCS_ADV_BIT];
                end
                `LDCS_REG_FIRST: begin
                    if (s_axi_wstrb[0]) next_firstLink[7:0] = s_axi_wdata[7:0];
                    if (s_axi_wstrb[1]) next_firstLink[15:8] = s_axi_wdata[15:8];
                end
                `LDCS_REG_IRQ_STAT: begin
                    if (s_axi_wstrb[0]) next_irqStat = irqStat & ~s_axi_wdata[1:0];
                end
                `LDCS_REG_IRQ_MASK: begin
                    if (s_axi_wstrb[0]) next_irqMask = s_axi_wdata[1:0];
                end
                `LDCS_REG_STATUS: begin
                end
                default: next_bresp = `LDCS_RESP_SLVERR;
            endcase
        end
        next_irqStat[`LDCS_IRQ_LINK]  = next_irqStat[`LDCS_IRQ_LINK] | evtLink;
        next_irqStat[`LDCS_IRQ_CHAIN] = next_irqStat[`LDCS_IRQ_CHAIN] | evtChain;
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = `LDCS_RESP_OKAY;
            unique case (s_axi_araddr)
                `LDCS_REG_CTRL:     next_rdata = {31'h0, run};
                `LDCS_REG_ADVANCE:  next_rdata = {31'h0, advBit};
                `LDCS_REG_FIRST:    next_rdata = {16'h0, firstLink};
                `LDCS_REG_STATUS:   next_rdata = {10'h0, state, linkAddr};
                `LDCS_REG_IRQ_STAT: next_rdata = {30'h0, irqStat};
                `LDCS_REG_IRQ_MASK: next_rdata = {30'h0, irqMask};
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = `LDCS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            run       <= `LDCS_RST_CTRL;
            advBit    <= `LDCS_RST_CTRL;
            firstLink <= `LDCS_RST_FIRST;
            irqStat   <= `LDCS_RST_IRQ;
            irqMask   <= `LDCS_RST_IRQ;
            bvalid    <= 1'b0;
            bresp     <= `LDCS_RESP_OKAY;
            rvalid    <= 1'b0;
            rresp     <= `LDCS_RESP_OKAY;
            rdata     <= 32'h0;
        end else begin
            run       <= next_run;
            advBit    <= next_advBit;
            firstLink <= next_firstLink;
            irqStat   <= next_irqStat;
            irqMask   <= next_irqMask;
            bvalid    <= next_bvalid;
            bresp     <= next_bresp;
            rvalid    <= next_rvalid;
            rresp     <= next_rresp;
            rdata     <= next_rdata;
        end
    end

    // level interrupt from masked sticky status
    assign irq = |(irqStat & irqMask);

    // ------------------------------------------------------------------
    // link sequencer
    // ------------------------------------------------------------------
    // only named flag fields are decoded, reserved bits never read
    assign linkFinal = !(desc.flags[`LDCS_CW_STEP]
                       && (passCnt + 16'h0001) < desc.flags[`LDCS_CW_LOOPCNT]);
    // first link or manual mode needs an advance toggle
    assign launchOk  = (!firstLinkOfChain && desc.flags[`LDCS_CW_AUTO])
                       || (advBit != advRef);

    // next state of the descriptor walk
    always_comb begin
        next_state            = state;
        next_desc             = desc;
        next_curDest          = curDest;
        next_passCnt          = passCnt;
        next_linkAddr         = linkAddr;
        next_firstLinkOfChain = firstLinkOfChain;
        next_advRef           = advRef;
        next_xferOrder        = xferOrder;
        next_xferStart        = 1'b0;
        next_xferAbort        = 1'b0;
        next_evtLink          = 1'b0;
        next_evtChain         = 1'b0;
        next_irqPulse         = |({evtChain, evtLink} & irqMask);
        unique case (state)
            ldcs_pkg::ST_IDLE: begin
                if (run && !runPrev) begin
                    next_linkAddr         = firstLink;
                    next_firstLinkOfChain = 1'b1;
                    next_advRef           = advBit;
                    next_state            = ldcs_pkg::ST_FETCH;
                end
            end
            ldcs_pkg::ST_FETCH: begin
                if (descValid) begin
                    next_desc    = descData;
                    next_curDest = descData.destAddr;
                    next_passCnt = 16'h0000;
                    next_state   = ldcs_pkg::ST_ARM;
                end
            end
            ldcs_pkg::ST_ARM: begin
                if (launchOk) begin
                    next_advRef = advBit;
                    next_state  = ldcs_pkg::ST_GATE;
                end
            end
            ldcs_pkg::ST_GATE: begin
                if (!desc.flags[`LDCS_CW_SOPGATE] || (streamSop && streamGate)) begin
                    next_xferStart                    = 1'b1;
                    next_xferOrder.destAddr           = curDest;
                    next_xferOrder.metaAddr           = desc.metaAddr;
                    next_xferOrder.byteCount          = desc.byteCount;
                    next_xferOrder.requestAddressKind = desc.flags[`LDCS_CW_KIND];
                    next_xferOrder.metaEnable         = desc.flags[`LDCS_CW_META];
                    next_xferOrder.stopOnEop          = desc.flags[`LDCS_CW_STOPEOP];
                    next_state                        = ldcs_pkg::ST_RUN;
                end
            end
            ldcs_pkg::ST_RUN: begin
                if (desc.flags[`LDCS_CW_STOPEOP] && streamEop) begin
                    next_xferAbort = 1'b1;
                    next_state     = ldcs_pkg::ST_STEP;
                end else if (xferDone) begin
                    next_state = ldcs_pkg::ST_STEP;
                end
            end
            ldcs_pkg::ST_STEP: begin
                if (desc.flags[`LDCS_CW_STEP]) begin
                    next_curDest = curDest + {32'h0, desc.loopStride};
                end
                if (!linkFinal) begin
                    next_passCnt = passCnt + 16'h0001;
                    next_state   = ldcs_pkg::ST_GATE;
                end else begin
                    next_evtLink = desc.flags[`LDCS_CW_LINKIRQ];
                    if (desc.flags[`LDCS_CW_LAST]) begin
                        next_evtChain = desc.flags[`LDCS_CW_CHAINIRQ];
                        next_state    = ldcs_pkg::ST_IDLE;
                    end else begin
                        next_linkAddr         = desc.nextLink;
                        next_firstLinkOfChain = 1'b0;
                        next_state            = ldcs_pkg::ST_FETCH;
                    end
                end
            end
            default: next_state = ldcs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state            <= ldcs_pkg::ST_IDLE;
            desc             <= '0;
            curDest          <= 64'h0;
            passCnt          <= 16'h0000;
            linkAddr         <= 16'h0000;
            firstLinkOfChain <= 1'b1;
            advRef           <= 1'b0;
            runPrev          <= 1'b0;
            xferOrder        <= '0;
            xferStart        <= 1'b0;
            xferAbort        <= 1'b0;
            evtLink          <= 1'b0;
            evtChain         <= 1'b0;
            irqPulse         <= 1'b0;
        end else begin
            state            <= next_state;
            desc             <= next_desc;
            curDest          <= next_curDest;
            passCnt          <= next_passCnt;
            linkAddr         <= next_linkAddr;
            firstLinkOfChain <= next_firstLinkOfChain;
            advRef           <= next_advRef;
            runPrev          <= run;
            xferOrder        <= next_xferOrder;
            xferStart        <= next_xferStart;
            xferAbort        <= next_xferAbort;
            evtLink          <= next_evtLink;
            evtChain         <= next_evtChain;
            irqPulse         <= next_irqPulse;
        end
    end

    assign descReq  = (state == ldcs_pkg::ST_FETCH);
    assign descAddr = linkAddr;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_loop_repeat;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_STEP && !linkFinal) |=>
            state == ldcs_pkg::ST_GATE && passCnt == $past(passCnt) + 16'h0001;
    endproperty
    a_loop_repeat: assert property (p_loop_repeat) else $error("repeat pass lost");

    property p_order_fields;
        @(posedge clk) disable iff (sys_rst)
        xferStart |-> xferOrder.requestAddressKind == desc.flags[`LDCS_CW_KIND]
            && xferOrder.metaEnable == desc.flags[`LDCS_CW_META];
    endproperty
    a_order_fields: assert property (p_order_fields) else $error("order fields wrong");

    property p_final_link;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_STEP && linkFinal && desc.flags[`LDCS_CW_LAST]) |=>
            state == ldcs_pkg::ST_IDLE ##1 !descReq;
    endproperty
    a_final_link: assert property (p_final_link) else $error("fetch after last");

    property p_chain_evt;
        @(posedge clk) disable iff (sys_rst)
        evtChain |-> $past(state == ldcs_pkg::ST_STEP && linkFinal
            && desc.flags[`LDCS_CW_LAST] && desc.flags[`LDCS_CW_CHAINIRQ]);
    endproperty
    a_chain_evt: assert property (p_chain_evt) else $error("bad chain event");

    property p_link_evt;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_STEP && linkFinal && desc.flags[`LDCS_CW_LINKIRQ]) |=>
            evtLink ##1 !evtLink;
    endproperty
    a_link_evt: assert property (p_link_evt) else $error("link event missing");

    property p_eop_stop;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_RUN && desc.flags[`LDCS_CW_STOPEOP] && streamEop) |=>
            xferAbort && state == ldcs_pkg::ST_STEP;
    endproperty
    a_eop_stop: assert property (p_eop_stop) else $error("eop did not stop");

    property p_eop_ignored;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_RUN && !desc.flags[`LDCS_CW_STOPEOP] && !xferDone) |=>
            state == ldcs_pkg::ST_RUN && !xferAbort;
    endproperty
    a_eop_ignored: assert property (p_eop_ignored) else $error("early end");

    property p_stride;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_STEP && desc.flags[`LDCS_CW_STEP]) |=>
            curDest == $past(curDest) + {32'h0, $past(desc.loopStride)};
    endproperty
    a_stride: assert property (p_stride) else $error("stride not added");

    property p_gate_wait;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_GATE && desc.flags[`LDCS_CW_SOPGATE]
            && !(streamSop && streamGate)) |=> !xferStart;
    endproperty
    a_gate_wait: assert property (p_gate_wait) else $error("launch without gate");

    property p_advance_wait;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_ARM && (firstLinkOfChain || !desc.flags[`LDCS_CW_AUTO])
            && advBit == advRef) |=> state == ldcs_pkg::ST_ARM;
    endproperty
    a_advance_wait: assert property (p_advance_wait) else $error("launch w/o toggle");

    property p_auto_go;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_ARM && !firstLinkOfChain && desc.flags[`LDCS_CW_AUTO]) |=>
            state == ldcs_pkg::ST_GATE;
    endproperty
    a_auto_go: assert property (p_auto_go) else $error("auto launch stalled");

    property p_successor;
        @(posedge clk) disable iff (sys_rst)
        (state == ldcs_pkg::ST_STEP && linkFinal && !desc.flags[`LDCS_CW_LAST]) |=>
            descReq && descAddr == $past(desc.nextLink);
    endproperty
    a_successor: assert property (p_successor) else $error("wrong successor");

    property p_pulse;
        @(posedge clk) disable iff (sys_rst)
        irqPulse |-> $past(|({evtChain, evtLink} & irqMask)) ##1 !irqPulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("irq pulse wrong");

endmodule

// ---- testbench/ldcs_partner.sv ----
/* far side model: descriptor store and data mover of the sequencer.
   assumes the bench preloads mem before starting a chain. */
`timescale 1ns/1ps
module ldcs_partner (
    input  wire logic           clk,
    input  wire logic           descReq,
    input  wire logic [15:0]    descAddr,
    output logic                descValid = 1'h0,
    output ldcs_pkg::ldcs_desc_t descData = '0,
    input  wire logic           xferStart,
    input  wire logic           xferAbort,
    output logic                xferDone = 1'h0
);
    ldcs_pkg::ldcs_desc_t mem [0:15];
    int                   cnt = 0;
    // one-beat answer a cycle after a request; data scrambled when idle
    always @(posedge clk) begin
        descValid <= descReq && !descValid;
        descData  <= descReq ? mem[descAddr[3:0]] : ~descData;
    end
    // byte count reached nine cycles after a start, dropped on abort
    always @(posedge clk) begin
        xferDone <= cnt == 1;
        cnt      <= xferStart ? 8 : (xferAbort ? 0 : (cnt > 0 ? cnt - 1 : 0));
    end
endmodule

// ---- testbench/ldcs_sequencer_bench.sv ----
/* self-checking bench of the link descriptor sequencer.
   assumes ldcs_pkg and the partner model are compiled first. */
`timescale 1ns/1ps
module ldcs_sequencer_bench;
    logic clk = 0, sys_rst = 1, adv = 0, streamSop = 0, streamEop = 0, streamGate = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, descReq, descValid, xferStart, xferAbort, xferDone, irq, irqPulse;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, gotResp;
    logic [15:0] descAddr;
    ldcs_pkg::ldcs_desc_t descData;
    ldcs_pkg::ldcs_xfer_t xferOrder;
    int errors = 0, n_compared = 0, starts = 0, aborts = 0, pulses = 0;
    typedef struct {logic [31:0] fl; int st; logic [1:0] irq; int pl; logic [63:0] dst;
        logic [1:0] mk;} ldcs_row_t;
    ldcs_row_t rows [6] = '{
        '{32'h0000_0500, 1, 2'h1, 1, 64'h1000, 2'h3},
        '{32'h0000_1e00, 1, 2'h2, 1, 64'h1000, 2'h3},
        '{32'h0000_2480, 1, 2'h0, 0, 64'h1000, 2'h3},
        '{32'h0000_f472, 1, 2'h0, 0, 64'h1000, 2'h3},
        '{32'h0003_0508, 3, 2'h1, 1, 64'h1080, 2'h3},
        '{32'h0000_0501, 1, 2'h1, 0, 64'h1000, 2'h0}};
    ldcs_sequencer i_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .descReq, .descAddr,
        .descValid, .descData, .streamSop, .streamEop, .streamGate, .xferStart,
        .xferAbort, .xferOrder, .xferDone, .irq, .irqPulse);
    ldcs_partner i_partner (.clk, .descReq, .descAddr, .descValid, .descData,
        .xferStart, .xferAbort, .xferDone);
    initial begin
        forever #12.5 clk = ~clk;
    end
    // count launches, eop ends and interrupt pulses
    always @(posedge clk) begin
        starts <= starts + xferStart;
        aborts <= aborts + xferAbort;
        pulses <= pulses + irqPulse;
    end
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // bounded wait step; an exhausted bound ends the run
    task automatic tick(inout int k);
        @(negedge clk);
        k++;
        if (k > 400) begin
            errors++;
            give_verdict();
        end
    endtask
    // one AXI4-Lite write (w=1) or read (w=0)
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} <= {w, w, !w, 2'h3};
        do tick(k); while (!(w ? s_axi_awready : s_axi_arready));
        @(posedge clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
        do tick(k); while (!(w ? s_axi_bvalid : s_axi_rvalid));
        got = s_axi_rdata;
        gotResp = w ? s_axi_bresp : s_axi_rresp;
        @(posedge clk);
        {s_axi_bready, s_axi_rready} <= 2'h0;
    endtask
    task automatic waitN(input int n);
        int k = 0;
        do tick(k); while (starts < n);
    endtask
    // start a chain; the first link must hold until the advance toggle
    task automatic run();
        bus(1, 8'h00, 0);
        bus(1, 8'h00, 1);
        // clear off the edge so the counting process cannot overwrite it
        @(negedge clk);
        {starts, aborts, pulses} = 96'h0;
        repeat (8) @(posedge clk);
        chk("held", 0, starts);
        adv = !adv;
        bus(1, 8'h04, {31'h0, adv});
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 0;
        foreach (rows[i]) begin
            i_partner.mem[0] = '{rows[i].fl, 32'h100, 64'h1000, 64'h2000, 32'h40, 16'h5};
            streamEop <= 1;
            bus(1, 8'h14, {30'h0, rows[i].mk});
            run();
            waitN(rows[i].st);
            repeat (20) @(posedge clk);
            chk("launches", rows[i].st, starts);
            chk("aborts", rows[i].fl[7], aborts);
            chk("kind", rows[i].fl[13:12], xferOrder.requestAddressKind);
            chk("meta", rows[i].fl[11], xferOrder.metaEnable);
            chk("eopMode", rows[i].fl[7], xferOrder.stopOnEop);
            chk("bytes", 32'h100, xferOrder.byteCount);
            chk("dest", rows[i].dst, xferOrder.destAddr);
            chk("pulses", rows[i].pl, pulses);
            chk("irq", |(rows[i].irq & rows[i].mk), irq);
            bus(0, 8'h10, 0);
            chk("irqStat", rows[i].irq, got[1:0]);
            bus(1, 8'h10, 32'h3);
            chk("wrResp", 2'h0, gotResp);
            chk("irqClear", 0, irq);
        end
        // manual link, then an auto gated link fetched from address 5
        streamEop <= 0;
        i_partner.mem[0] = '{32'h0, 32'h100, 64'h1000, 64'h2000, 32'h40, 16'h5};
        i_partner.mem[5] = '{32'h0485, 32'h100, 64'h3000, 64'h2000, 32'h40, 16'h0};
        run();
        waitN(1);
        repeat (20) @(posedge clk);
        streamSop <= 1;
        repeat (4) @(posedge clk);
        chk("gateLow", 1, starts);
        streamGate <= 1;
        waitN(2);
        chk("nextLink", 64'h3000, xferOrder.destAddr);
        @(posedge clk);
        streamEop <= 1;
        repeat (3) @(posedge clk);
        chk("eopEnd", 1, aborts);
        bus(0, 8'h3c, 0);
        chk("unmapped", 2'h2, gotResp);
        // reset in mid-run: registers and walk back to their idle values
        @(posedge clk);
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        bus(0, 8'h0c, 0);
        chk("rstStatus", 32'h0001_0000, got);
        bus(0, 8'h00, 0);
        chk("rstRun", 0, got);
        give_verdict();
    end
endmodule
